// ==== gpfs_defines.svh ====
`ifndef GPFS_DEFINES_SVH
`define GPFS_DEFINES_SVH

// pin indices within the five-pin port
`define GPFS_STRAP_PIN     0
`define GPFS_FREQ_PIN      1
`define GPFS_COEX_LO_PIN   2
`define GPFS_COEX_HI_PIN   4

// reset values
`define GPFS_DIR_RST       5'h00
`define GPFS_OUT_RST       5'h00
`define GPFS_PULL_RST      5'h00
`define GPFS_COEX_SEL_RST  1'b1
`define GPFS_FREQ_SEL_RST  1'b0
`define GPFS_UART_SEL_RST  1'b0

// cycles after reset release before the strap is captured
`define GPFS_STRAP_DELAY   2

`endif

// ==== gpfs_pkg.sv ====
package gpfs_pkg;
    typedef enum logic [1:0] {
        GPFS_PULL_NONE = 2'b00,
        GPFS_PULL_UP   = 2'b01,
        GPFS_PULL_DOWN = 2'b10
    } gpfs_pull_t;

    typedef logic [4:0] gpfs_pins_t;
endpackage

// ==== gpfs_sync.sv ====
module gpfs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    initial begin
        if (WIDTH < 1) begin
            $error("gpfs_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end
endmodule // gpfs_sync

// ==== gpfs_gpio.sv ====
`include "gpfs_defines.svh"

module gpfs_gpio #(
    parameter int NUM_PINS    = 5,
    parameter int STRAP_DELAY = `GPFS_STRAP_DELAY
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // software control bits
    input  wire gpfs_pkg::gpfs_pins_t pinDirOutIn,
    input  wire gpfs_pkg::gpfs_pins_t pinOutValIn,
    input  wire logic [9:0]          pinPullIn,
    input  wire logic               ctlWrite,
    input  wire logic               coexSelIn,
    input  wire logic               freqSelIn,
    input  wire logic               uartSelIn,
    // software status
    output gpfs_pkg::gpfs_pins_t    pinInVal,
    output logic                    hostStrap,
    output logic                    strapValid,
    output gpfs_pkg::gpfs_pins_t    pinDirOut,
    output logic                    coexSel,
    output logic                    freqSel,
    output logic                    uartSel,
    // pads: index 0 is pin 0 ... index 4 is pin 5 (no pin 2)
    input  wire gpfs_pkg::gpfs_pins_t padIn,
    output gpfs_pkg::gpfs_pins_t    padOut,
    output gpfs_pkg::gpfs_pins_t    padOe,
    output gpfs_pkg::gpfs_pins_t    padPullUp,
    output gpfs_pkg::gpfs_pins_t    padPullDown,
    // coexistence function
    input  wire logic               coexTxConf,
    input  wire logic               coexStatus,
    output logic                    coexRfActive,
    input  wire logic               coexFreq,
    // debug serial and test port
    input  wire logic               uartTx,
    output logic                    uartRx,
    input  wire logic               testTdiIn,
    input  wire logic               testTdo,
    input  wire logic               testTdoOe,
    output logic                    testTdoPad,
    output logic                    testTdoPadOe
);
    import gpfs_pkg::*;

    initial begin
        if (NUM_PINS != 5) begin
            $error("gpfs_gpio: NUM_PINS must be 5");
        end
        if (STRAP_DELAY < 1 || STRAP_DELAY > 15) begin
            $error("gpfs_gpio: STRAP_DELAY out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control state

    gpfs_pins_t dir_q;
    gpfs_pins_t out_q;
    logic [9:0] pull_q;
    logic       coexSel_q;
    logic       freqSel_q;
    logic       uartSel_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dir_q  <= `GPFS_DIR_RST;
            out_q  <= `GPFS_OUT_RST;
            pull_q <= {`GPFS_PULL_RST, `GPFS_PULL_RST};
        end else if (ctlWrite) begin
            dir_q  <= pinDirOutIn;
            out_q  <= pinOutValIn;
            pull_q <= pinPullIn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            coexSel_q <= `GPFS_COEX_SEL_RST;
            freqSel_q <= `GPFS_FREQ_SEL_RST;
            uartSel_q <= `GPFS_UART_SEL_RST;
        end else if (ctlWrite) begin
            coexSel_q <= coexSelIn;
            freqSel_q <= freqSelIn;
            uartSel_q <= uartSelIn;
        end
    end

    assign pinDirOut = dir_q;
    assign coexSel   = coexSel_q;
    assign freqSel   = freqSel_q;
    assign uartSel   = uartSel_q;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    gpfs_pins_t padSync;
    logic       tdiSync;

    gpfs_sync #(
        .WIDTH (NUM_PINS + 1)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .asyncIn ({testTdiIn, padIn}),
        .syncOut ({tdiSync, padSync})
    );

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pinInVal <= '0;
            uartRx   <= 1'b1;
        end else begin
            pinInVal <= padSync;
            uartRx   <= uartSel_q ? tdiSync : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture after reset release

    logic [3:0] strapCnt_q;
    logic       hostStrap_q;
    logic       strapValid_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            strapCnt_q   <= 4'h0;
            strapValid_q <= 1'b0;
            hostStrap_q  <= 1'b0;
        end else if (!strapValid_q) begin
            strapCnt_q <= strapCnt_q + 4'h1;
            if (strapCnt_q == 4'(STRAP_DELAY)) begin
                hostStrap_q  <= padSync[`GPFS_STRAP_PIN];
                strapValid_q <= 1'b1;
            end
        end
    end

    assign hostStrap  = hostStrap_q;
    assign strapValid = strapValid_q;

    ////////////////////////////////////////////////////////////////////////
    // pin multiplexing

    gpfs_pins_t altSel;
    gpfs_pins_t altOut;
    gpfs_pins_t altOe;

    always_comb begin
        altSel = '0;
        altOut = '0;
        altOe  = '0;
        altSel[`GPFS_FREQ_PIN] = freqSel_q;
        altOut[`GPFS_FREQ_PIN] = coexFreq;
        altOe[`GPFS_FREQ_PIN]  = 1'b1;
        altSel[`GPFS_COEX_HI_PIN:`GPFS_COEX_LO_PIN] = {3{coexSel_q}};
        altOut[`GPFS_COEX_LO_PIN]     = coexTxConf;
        altOut[`GPFS_COEX_LO_PIN + 1] = coexStatus;
        altOe[`GPFS_COEX_LO_PIN]      = 1'b1;
        altOe[`GPFS_COEX_LO_PIN + 1]  = 1'b1;
    end

    // alternate output source is a live signal, so registered per pin
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            padOut <= '0;
            padOe  <= '0;
        end else begin
            padOut <= (altSel & altOut) | (~altSel & out_q);
            padOe  <= (altSel & altOe) | (~altSel & dir_q);
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pull
            assign padPullUp[i]   = pull_q[2*i +: 2] == GPFS_PULL_UP;
            assign padPullDown[i] = pull_q[2*i +: 2] == GPFS_PULL_DOWN;
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            coexRfActive <= 1'b0;
        end else begin
            coexRfActive <= coexSel_q & padSync[`GPFS_COEX_HI_PIN];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            testTdoPad   <= 1'b0;
            testTdoPadOe <= 1'b0;
        end else begin
            testTdoPad   <= uartSel_q ? uartTx : testTdo;
            testTdoPadOe <= uartSel_q ? 1'b1 : testTdoOe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    // strap flag rises this many edges after reset release
    localparam int STRAP_SEEN = STRAP_DELAY + 1;

    // pads without an alternate driver stay off in the first two cycles
    sequence s_floatAtRelease;
        padOe == 5'h00 ##1
        padOe[`GPFS_FREQ_PIN:`GPFS_STRAP_PIN] == 2'b00 &&
        !padOe[`GPFS_COEX_HI_PIN];
    endsequence
    a_reset_float: assert property (
        @(posedge clk_sys)
        $fell(sys_rst) |-> s_floatAtRelease)
        else $error("pad driven right after reset");

    a_coex_default: assert property (
        @(posedge clk_sys)
        $fell(sys_rst) |-> coexSel_q && !freqSel_q && !uartSel_q)
        else $error("select bits wrong at reset release");

    sequence s_coexOff;
        !sys_rst && !coexSel_q && !freqSel_q;
    endsequence
    a_gpio_drive: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        s_coexOff ##1 !$past(sys_rst) |-> padOe == $past(dir_q))
        else $error("pad enable does not follow direction");

    a_gpio_value: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !$past(coexSel_q) && !$past(freqSel_q) |-> padOut == $past(out_q))
        else $error("pad value does not follow output bits");

    a_alt_drives: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $past(coexSel_q) && !$past(sys_rst) |->
        padOut[`GPFS_COEX_LO_PIN] == $past(coexTxConf) &&
        padOe[`GPFS_COEX_LO_PIN])
        else $error("coexistence pin not driven by alternate");

    a_coex_status: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $past(coexSel_q) && !$past(sys_rst) |->
        padOut[`GPFS_COEX_LO_PIN + 1] == $past(coexStatus) &&
        padOe[`GPFS_COEX_LO_PIN + 1] && !padOe[`GPFS_COEX_HI_PIN])
        else $error("coexistence status pin not driven");

    a_freq_route: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $past(freqSel_q) && !$past(sys_rst) |->
        padOut[`GPFS_FREQ_PIN] == $past(coexFreq))
        else $error("frequency pin not routed");

    a_uart_tx: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $past(uartSel_q) && !$past(sys_rst) |->
        testTdoPad == $past(uartTx) && testTdoPadOe)
        else $error("serial transmit not on test output");

    a_uart_rx: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $past(uartSel_q) && !$past(sys_rst) |-> uartRx == $past(tdiSync))
        else $error("serial receive not taken from test input");

    a_uart_idle: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !$past(uartSel_q) |-> uartRx)
        else $error("serial receive active while disabled");

    sequence s_strapRise;
        strapValid_q && !$past(strapValid_q);
    endsequence
    a_strap_time: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |-> ##STRAP_SEEN s_strapRise)
        else $error("strap captured at the wrong time");

    a_strap_hold: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        strapValid_q |=> strapValid_q && $stable(hostStrap_q))
        else $error("strap value changed after capture");

    a_pull_up: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ctlWrite && pinPullIn[1:0] == GPFS_PULL_UP |=>
        padPullUp[0] && !padPullDown[0])
        else $error("pull-up request not applied");

    a_pull_down: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ctlWrite && pinPullIn[3:2] == GPFS_PULL_DOWN |=>
        padPullDown[1] && !padPullUp[1])
        else $error("pull-down request not applied");
endmodule // gpfs_gpio

// ==== gpfs_pad_model.sv ====
module gpfs_pad_model (
    // clock
    input  wire logic            clk_sys,
    // design pads
    input  wire gpfs_pkg::gpfs_pins_t padOut,
    input  wire gpfs_pkg::gpfs_pins_t padOe,
    input  wire gpfs_pkg::gpfs_pins_t padPullUp,
    input  wire gpfs_pkg::gpfs_pins_t padPullDown,
    // external devices
    input  wire gpfs_pkg::gpfs_pins_t extVal,
    input  wire gpfs_pkg::gpfs_pins_t extEn,
    output gpfs_pkg::gpfs_pins_t     padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpfs_pkg::*;

    gpfs_pins_t floatPat_q = 5'h0A;

    // a pad nobody drives or pulls shows a changing level
    always_ff @(posedge clk_sys) begin
        floatPat_q <= ~floatPat_q;
    end

    always_comb begin
        for (int k = 0; k < 5; k++) begin
            if (padOe[k])
                padIn[k] = padOut[k];
            else if (extEn[k])
                padIn[k] = extVal[k];
            else if (padPullUp[k])
                padIn[k] = 1'b1;
            else if (padPullDown[k])
                padIn[k] = 1'b0;
            else
                padIn[k] = floatPat_q[k];
        end
    end
endmodule // gpfs_pad_model

// ==== testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import gpfs_pkg::*;

    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    gpfs_pins_t pinDirOutIn = 5'h00, pinOutValIn = 5'h00, pinInVal, pinDirOut;
    gpfs_pins_t padIn, padOut, padOe, padPullUp, padPullDown;
    gpfs_pins_t extVal = 5'h01, extEn = 5'h01;
    logic [9:0] pinPullIn = 10'h000;
    logic ctlWrite = 1'b0, coexSelIn = 1'b1, freqSelIn = 1'b0;
    logic uartSelIn = 1'b0, hostStrap, strapValid, coexSel, freqSel;
    logic uartSel, coexTxConf = 1'b0, coexStatus = 1'b0, coexRfActive;
    logic coexFreq = 1'b0, uartTx = 1'b1, uartRx, testTdiIn = 1'b1;
    logic testTdo = 1'b1, testTdoOe = 1'b0, testTdoPad, testTdoPadOe;
    int fail_count = 0;
    int checks = 0;

    always #25 clk_sys = ~clk_sys;

    gpfs_gpio dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pinDirOutIn(pinDirOutIn), .pinOutValIn(pinOutValIn),
        .pinPullIn(pinPullIn), .ctlWrite(ctlWrite), .coexSelIn(coexSelIn),
        .freqSelIn(freqSelIn), .uartSelIn(uartSelIn), .pinInVal(pinInVal),
        .hostStrap(hostStrap), .strapValid(strapValid),
        .pinDirOut(pinDirOut), .coexSel(coexSel), .freqSel(freqSel),
        .uartSel(uartSel), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .padPullUp(padPullUp), .padPullDown(padPullDown),
        .coexTxConf(coexTxConf), .coexStatus(coexStatus),
        .coexRfActive(coexRfActive), .coexFreq(coexFreq), .uartTx(uartTx),
        .uartRx(uartRx), .testTdiIn(testTdiIn), .testTdo(testTdo),
        .testTdoOe(testTdoOe), .testTdoPad(testTdoPad),
        .testTdoPadOe(testTdoPadOe));

    gpfs_pad_model pads (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe),
        .padPullUp(padPullUp), .padPullDown(padPullDown), .extVal(extVal),
        .extEn(extEn), .padIn(padIn));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // load all control fields, then let pads and synchronisers settle
    task automatic ctl_write(input gpfs_pins_t dir, input gpfs_pins_t val,
                             input logic [9:0] pull, input logic cx,
                             input logic fq, input logic ua);
        @(posedge clk_sys);
        pinDirOutIn <= dir;
        pinOutValIn <= val;
        pinPullIn   <= pull;
        coexSelIn   <= cx;
        freqSelIn   <= fq;
        uartSelIn   <= ua;
        ctlWrite    <= 1'b1;
        @(posedge clk_sys);
        ctlWrite <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset for four edges, release, then wait for the strap capture
    task automatic reset_wait(output bit late);
        int n;
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(padOe, 5'h0C);
        check({coexSel, freqSel, uartSel, uartRx}, 4'h9);
        check(padPullUp | padPullDown, 5'h00);
        n = 0;
        while (strapValid !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        late = (n >= 20);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        bit late;
        reset_wait(late);
        if (late) begin
            fail_count++;
        end else begin
            check(hostStrap, 1'b1);
            @(posedge clk_sys);
            extEn      <= 5'h10;
            extVal     <= 5'h10;
            coexTxConf <= 1'b1;
            coexStatus <= 1'b1;
            ctl_write(5'h1F, 5'h0A, 10'h000, 1'b1, 1'b0, 1'b0);
            check(padOe, 5'h0F);
            check(padOut[3:0], 4'hE);
            check(pinDirOut, 5'h1F);
            check(coexRfActive, 1'b1);
            ctl_write(5'h1F, 5'h0A, 10'h000, 1'b0, 1'b0, 1'b0);
            check(pinDirOut, 5'h1F);
            check({padOe, padOut}, 10'h3EA);
            @(posedge clk_sys);
            extEn <= 5'h00;
            ctl_write(5'h00, 5'h00, 10'h1C9, 1'b0, 1'b0, 1'b0);
            check({padPullUp, padPullDown}, 10'h222);
            check(padOe, 5'h00);
            check(pinInVal & 5'h13, 5'h11);
            @(posedge clk_sys);
            coexFreq <= 1'b1;
            ctl_write(5'h00, 5'h00, 10'h000, 1'b0, 1'b1, 1'b0);
            check({padOe[1], padOut[1]}, 2'h3);
            @(posedge clk_sys);
            coexFreq <= 1'b0;
            repeat (2) @(posedge clk_sys);
            #1;
            check(padOut[1], 1'b0);
            @(posedge clk_sys);
            testTdiIn <= 1'b0;
            uartTx    <= 1'b0;
            repeat (4) @(posedge clk_sys);
            #1;
            check({uartRx, testTdoPad, testTdoPadOe}, 3'h6);
            ctl_write(5'h00, 5'h00, 10'h000, 1'b0, 1'b0, 1'b1);
            check({uartRx, testTdoPad, testTdoPadOe}, 3'h1);
            @(posedge clk_sys);
            extEn  <= 5'h01;
            extVal <= 5'h00;
            reset_wait(late);
            if (late) begin
                fail_count++;
            end else begin
                check(hostStrap, 1'b0);
            end
        end
        final_report();
    end
endmodule // testbench
